//--- verilog/comparator_event_regs.svh
// Behaviour
// - The comparator, its event detection and its pin drive work only while comparator_enable is 1.
// - reference_select picks the non-inverting input: 0 the positive pin, 1 the internal bandgap.
// - compare_event_flag sets on a configured compare event and clears only when software writes a one.
// - With compare_irq_enable at 1 the interrupt request is high while the flag is set, otherwise low.
// - comparator_output_value reads the present comparator output and reads 0 while disabled.
// - The comparator output drives comparator_out_pin only when output_pin_enable and enable are both 1.
// - event_mode selects the edge: 00 falling, 01 rising, 10 falling, 11 either.
// - In wait mode an enabled block keeps working and a flagged enabled event requests wake-up.
// - In stop mode an enabled block keeps comparing, driving the pin, flagging and requesting stop exit.
// - Leaving stop through reset returns every control and status bit to its reset value.
// - In background debug mode the block keeps working with no suspension.
// - The comparator output is high when the non-inverting input exceeds the inverting input.
`ifndef COMPARATOR_EVENT_REGS_SVH
`define COMPARATOR_EVENT_REGS_SVH
`define CMP_ADDR_STATUS_CONTROL 2'h0
`define CMP_ADDR_IRQ_STATUS     2'h1
`define CMP_ADDR_IRQ_MASK       2'h2
`define CMP_BIT_ENABLE          7
`define CMP_BIT_REFSEL          6
`define CMP_BIT_FLAG            5
`define CMP_BIT_IRQEN           4
`define CMP_BIT_OUTVAL          3
`define CMP_BIT_PINEN           2
`define CMP_CTRL_RESET          8'h00
`define CMP_MODE_FALL0          2'h0
`define CMP_MODE_RISE           2'h1
`define CMP_MODE_FALL2          2'h2
`define CMP_MODE_EITHER         2'h3
`define CMP_BUS_IDLE_DATA       32'h00000000
`endif

//--- verilog/comparator_event_pkg.sv
package comparator_event_pkg;
    typedef enum logic [1:0] {
        MODE_FALL_A = 2'b00,
        MODE_RISE   = 2'b01,
        MODE_FALL_B = 2'b10,
        MODE_EITHER = 2'b11
    } event_mode_t;
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_ANSWER = 2'b01
    } bus_state_t;
endpackage

//--- verilog/comparator_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for the analog comparator decision
module comparator_sync (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic firstStage;

    // first stage is read only by the second stage
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            firstStage <= 1'b0;
            syncOut    <= 1'b0;
        end else begin
            firstStage <= asyncIn;
            syncOut    <= firstStage;
        end
    end
endmodule

//--- verilog/edge_event_detect.sv
`timescale 1ns/1ps
`include "comparator_event_regs.svh"
// turns the synchronised comparator level into one-cycle compare events
module edge_event_detect (
    input  wire logic                              core_clk,
    input  wire logic                              sys_rst,
    input  wire logic                              enable,
    input  wire logic                              level,
    input  wire comparator_event_pkg::event_mode_t mode,
    output logic                                   eventPulse
);
    logic lastLevel;
    logic rising;
    logic falling;

    // history held low while disabled: a level already high at enable counts as a rising edge
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lastLevel <= 1'b0;
        end else begin
            lastLevel <= enable ? level : 1'b0;
        end
    end

    assign rising  = level & ~lastLevel;
    assign falling = ~level & lastLevel;

    // edge selection by mode
    always_comb begin
        case (mode)
            comparator_event_pkg::MODE_FALL_A: eventPulse = enable & falling;
            comparator_event_pkg::MODE_RISE:   eventPulse = enable & rising;
            comparator_event_pkg::MODE_FALL_B: eventPulse = enable & falling;
            comparator_event_pkg::MODE_EITHER: eventPulse = enable & (rising | falling);
            default:                           eventPulse = 1'b0;
        endcase
    end
endmodule

//--- verilog/comparator_event_control.sv
`timescale 1ns/1ps
`include "comparator_event_regs.svh"
// comparator control, event flag, interrupt and avalon-mm register slave
module comparator_event_control (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [1:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    input  wire logic        noninverting_pin,
    input  wire logic        bandgap_reference,
    input  wire logic        inverting_pin,
    input  wire logic        analog_compare_result,
    output logic             reference_select_out,
    output logic             comparator_power_on,
    output logic             comparator_out_pin,
    output logic             comparator_out_pin_oe_n,
    output logic             compare_irq,
    output logic             wakeup_request,
    output logic             irq
);
    logic        comparatorEnable;
    logic        referenceSelect;
    logic        compareEventFlag;
    logic        compareIrqEnable;
    logic        outputPinEnable;
    logic [1:0]  eventMode;
    logic        syncLevel;
    logic        eventPulse;
    logic        comparatorOutputValue;
    logic        irqStatus;
    logic        irqMask;
    logic        accessCycle;
    logic        ctrlWrite;
    logic        statusWrite;
    logic        maskWrite;
    logic [7:0]  ctrlView;
    logic [31:0] next_readdata;
    logic        addrValid;
    comparator_event_pkg::bus_state_t busState;

    // the analog decision itself lives outside; this block steers it and reads the result
    assign comparator_power_on  = comparatorEnable;
    assign reference_select_out = referenceSelect;

    comparator_sync u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .asyncIn  (analog_compare_result),
        .syncOut  (syncLevel)
    );

    edge_event_detect u_edge (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .enable     (comparatorEnable),
        .level      (syncLevel),
        .mode       (comparator_event_pkg::event_mode_t'(eventMode)),
        .eventPulse (eventPulse)
    );

    // visible output value forced low while disabled
    assign comparatorOutputValue = comparatorEnable & syncLevel;

    // bus handshake: one wait cycle, then the answer in the next cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            busState <= comparator_event_pkg::BUS_IDLE;
        end else begin
            case (busState)
                comparator_event_pkg::BUS_IDLE: begin
                    if (avs_read | avs_write) begin
                        busState <= comparator_event_pkg::BUS_ANSWER;
                    end
                end
                comparator_event_pkg::BUS_ANSWER: busState <= comparator_event_pkg::BUS_IDLE;
                default: busState <= comparator_event_pkg::BUS_IDLE;
            endcase
        end
    end

    assign accessCycle     = (busState == comparator_event_pkg::BUS_ANSWER);
    assign avs_waitrequest = (avs_read | avs_write) & ~accessCycle;
    assign addrValid       = (avs_address == `CMP_ADDR_STATUS_CONTROL) |
                             (avs_address == `CMP_ADDR_IRQ_STATUS) |
                             (avs_address == `CMP_ADDR_IRQ_MASK);
    assign ctrlWrite   = accessCycle & avs_write & avs_byteenable[0] & (avs_address == `CMP_ADDR_STATUS_CONTROL);
    assign statusWrite = accessCycle & avs_write & avs_byteenable[0] & (avs_address == `CMP_ADDR_IRQ_STATUS);
    assign maskWrite   = accessCycle & avs_write & avs_byteenable[0] & (avs_address == `CMP_ADDR_IRQ_MASK);

    // control fields; sync reset covers a reset that ends stop mode too
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            comparatorEnable <= 1'((`CMP_CTRL_RESET) >> `CMP_BIT_ENABLE);
            referenceSelect  <= 1'b0;
            compareIrqEnable <= 1'b0;
            outputPinEnable  <= 1'b0;
            eventMode        <= `CMP_MODE_FALL0;
        end else if (ctrlWrite) begin
            comparatorEnable <= avs_writedata[`CMP_BIT_ENABLE];
            referenceSelect  <= avs_writedata[`CMP_BIT_REFSEL];
            compareIrqEnable <= avs_writedata[`CMP_BIT_IRQEN];
            outputPinEnable  <= avs_writedata[`CMP_BIT_PINEN];
            eventMode        <= avs_writedata[1:0];
        end
    end

    // event flag: set beats a same-cycle write-one clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            compareEventFlag <= 1'b0;
        end else if (eventPulse) begin
            compareEventFlag <= 1'b1;
        end else if (ctrlWrite & avs_writedata[`CMP_BIT_FLAG]) begin
            compareEventFlag <= 1'b0;
        end
    end

    // sticky interrupt status, same set-wins priority
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irqStatus <= 1'b0;
        end else if (eventPulse) begin
            irqStatus <= 1'b1;
        end else if (statusWrite & avs_writedata[0]) begin
            irqStatus <= 1'b0;
        end
    end

    // interrupt mask register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irqMask <= 1'b0;
        end else if (maskWrite) begin
            irqMask <= avs_writedata[0];
        end
    end

    // no clock gating in wait, stop or debug: logic simply keeps running
    assign compare_irq    = compareIrqEnable & compareEventFlag;
    assign wakeup_request = compareIrqEnable & compareEventFlag;
    assign irq            = irqStatus & irqMask;

    // pin drive only while enabled; oe low means driving
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            comparator_out_pin      <= 1'b0;
            comparator_out_pin_oe_n <= 1'b1;
        end else begin
            comparator_out_pin      <= comparatorOutputValue;
            comparator_out_pin_oe_n <= ~(comparatorEnable & outputPinEnable);
        end
    end

    assign ctrlView = {comparatorEnable, referenceSelect, compareEventFlag, compareIrqEnable,
                       comparatorOutputValue, outputPinEnable, eventMode};

    // read data mux; unmapped reads zero with a slave error
    always_comb begin
        next_readdata = `CMP_BUS_IDLE_DATA;
        case (avs_address)
            `CMP_ADDR_STATUS_CONTROL: next_readdata = {24'h000000, ctrlView};
            `CMP_ADDR_IRQ_STATUS:     next_readdata = {31'h00000000, irqStatus};
            `CMP_ADDR_IRQ_MASK:       next_readdata = {31'h00000000, irqMask};
            default:                  next_readdata = `CMP_BUS_IDLE_DATA;
        endcase
    end

    // read data registered when the request is first seen, stands in answer cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            avs_readdata <= `CMP_BUS_IDLE_DATA;
            avs_response <= 2'h0;
        end else if (~accessCycle & (avs_read | avs_write)) begin
            avs_readdata <= avs_read ? next_readdata : `CMP_BUS_IDLE_DATA;
            avs_response <= addrValid ? 2'h0 : 2'h2;
        end
    end
endmodule

//--- test/comparator_event_monitor.sv
`timescale 1ns/1ps
module comparator_event_monitor (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic analog_compare_result,
    input wire logic comparator_power_on,
    input wire logic comparator_out_pin,
    input wire logic comparator_out_pin_oe_n,
    input wire logic compare_irq,
    input wire logic wakeup_request,
    input wire logic irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // a request waiting for its single answer cycle
    sequence s_req_wait; (avs_read || avs_write) && avs_waitrequest; endsequence
    // a level held while the block is on, long enough to cross both sync flops and the pin flop
    sequence s_steady_on; (comparator_power_on && $stable(analog_compare_result))[*4]; endsequence
    property p_one_wait; s_req_wait |=> !avs_waitrequest; endproperty
    a_one_wait: assert property (p_one_wait) else $error("waitrequest held past one cycle");
    property p_idle_ready; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
    a_idle_ready: assert property (p_idle_ready) else $error("waitrequest high with no request");
    property p_oe_off; $past(!comparator_power_on) |-> comparator_out_pin_oe_n; endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin driven while disabled");
    property p_pin_off; $past(!comparator_power_on) |-> !comparator_out_pin; endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin high while disabled");
    property p_pin_follow; s_steady_on |-> comparator_out_pin == analog_compare_result; endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("pin does not follow comparator");
    property p_wake_eq; compare_irq == wakeup_request; endproperty
    a_wake_eq: assert property (p_wake_eq) else $error("wake request differs from irq");
    property p_irq_fall; $fell(compare_irq) |-> $past(avs_write) && !$past(avs_waitrequest); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("compare irq dropped without a write");
    property p_irq_rise; $rose(compare_irq) |-> $past(comparator_power_on || avs_write); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("compare irq rose while disabled");
    property p_int_fall; $fell(irq) |-> $past(avs_write) && !$past(avs_waitrequest); endproperty
    a_int_fall: assert property (p_int_fall) else $error("interrupt dropped without a write");
endmodule
bind comparator_event_control comparator_event_monitor mon (.core_clk, .sys_rst, .avs_read, .avs_write,
    .avs_waitrequest, .analog_compare_result, .comparator_power_on, .comparator_out_pin,
    .comparator_out_pin_oe_n, .compare_irq, .wakeup_request, .irq);

//--- test/comparator_core_model.sv
`timescale 1ns/1ps
module comparator_core_model (
    input  wire logic powerOn,
    input  wire logic refSel,
    input  wire logic posLevel,
    input  wire logic bandgapLevel,
    input  wire logic negLevel,
    output logic      result
);
    // settles 7 ns after its inputs, so it never moves on a clock edge; low while unpowered
    assign #7 result = powerOn & (refSel ? bandgapLevel : posLevel) & !negLevel;
endmodule

//--- test/comparator_event_control_tb.sv
`timescale 1ns/1ps
module comparator_event_control_tb;
    logic        core_clk, sys_rst, avs_read, avs_write, noninverting_pin, bandgap_reference, inverting_pin;
    logic [1:0]  avs_address, avs_response;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable;
    logic        avs_waitrequest, cmpResult, refSel, powerOn, pinOut, pinOeN, cmpIrq, irq, wake;
    int          n_errors, cmp_count, m;
    comparator_event_control uut (.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .noninverting_pin, .bandgap_reference,
        .inverting_pin, .analog_compare_result(cmpResult), .reference_select_out(refSel),
        .comparator_power_on(powerOn), .comparator_out_pin(pinOut), .comparator_out_pin_oe_n(pinOeN),
        .compare_irq(cmpIrq), .wakeup_request(wake), .irq);
    comparator_core_model core (.powerOn, .refSel, .posLevel(noninverting_pin),
        .bandgapLevel(bandgap_reference), .negLevel(inverting_pin), .result(cmpResult));
    task stop_test; begin
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    end endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g); begin
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    end endtask
    // one bus transfer; one idle edge after release keeps requests apart
    task acc(input logic wr, input logic [1:0] a, input logic [7:0] d); int n; begin
        n = 0;
        avs_address <= a; avs_writedata <= {24'h0, d}; avs_write <= wr; avs_read <= !wr;
        do begin @(posedge core_clk); n++; end while (avs_waitrequest !== 1'h0 && n < 20);
        if (n >= 20) begin n_errors++; $display("CHECK FAILED waitrequest expected 0 seen 1"); stop_test; end
        q = avs_readdata;
        avs_read <= 1'h0; avs_write <= 1'h0;
        @(posedge core_clk);
    end endtask
    task tick(input int n); repeat (n) @(posedge core_clk); endtask
    initial begin core_clk = 0; forever #25 core_clk = ~core_clk; end
    initial begin
        sys_rst = 1; avs_read = 0; avs_write = 0; avs_address = 0; avs_writedata = 0; avs_byteenable = 4'hF;
        noninverting_pin = 0; bandgap_reference = 0; inverting_pin = 0; n_errors = 0; cmp_count = 0;
        tick(3); sys_rst <= 1'h0; tick(1);
        acc(0, 2'h0, 8'h00); chk("ctrl reset", 8'h00, q[7:0]);
        acc(0, 2'h3, 8'h00); chk("unmapped", 8'h00, q[7:0]);
        chk("unmapped response", 8'h02, {6'h0, avs_response});
        // every edge mode, rising then falling comparator output
        for (m = 0; m < 4; m++) begin
            acc(1, 2'h0, 8'hB4 | m[7:0]); tick(6); acc(1, 2'h0, 8'hB4 | m[7:0]);
            noninverting_pin <= 1'h1; tick(6); acc(0, 2'h0, 8'h00);
            chk("rise ctrl", 8'h9C | m[7:0] | (m[0] ? 8'h20 : 8'h00), q[7:0]);
            chk("rise irq", {7'h0, m[0]}, {7'h0, cmpIrq});
            chk("rise wake", {7'h0, m[0]}, {7'h0, wake});
            chk("pin drive", 8'h02, {6'h0, pinOut, pinOeN});
            acc(1, 2'h0, 8'hB4 | m[7:0]);
            noninverting_pin <= 1'h0; tick(6); acc(0, 2'h0, 8'h00);
            chk("fall ctrl", 8'h94 | m[7:0] | (m != 1 ? 8'h20 : 8'h00), q[7:0]);
        end
        acc(1, 2'h0, 8'h87); acc(0, 2'h0, 8'h00); chk("zero write keeps flag", 8'hA7, q[7:0]);
        chk("irq disabled", 8'h00, {7'h0, cmpIrq});
        acc(1, 2'h2, 8'h01); chk("irq masked on", 8'h01, {7'h0, irq});
        acc(1, 2'h1, 8'h01); chk("irq cleared", 8'h00, {7'h0, irq});
        noninverting_pin <= 1'h1; tick(6); chk("irq event", 8'h01, {7'h0, irq});
        acc(1, 2'h2, 8'h00); chk("irq mask off", 8'h00, {7'h0, irq});
        acc(0, 2'h1, 8'h00); chk("irq status", 8'h01, q[7:0]);
        // bandgap as non-inverting input, pin drive off
        acc(1, 2'h0, 8'hE3); tick(6); acc(0, 2'h0, 8'h00); chk("bandgap low", 8'hE3, q[7:0]);
        chk("pin released", 8'h01, {7'h0, pinOeN});
        bandgap_reference <= 1'h1; tick(6); acc(0, 2'h0, 8'h00); chk("bandgap high", 8'hEB, q[7:0]);
        acc(1, 2'h0, 8'h27); noninverting_pin <= 1'h0; tick(6); acc(0, 2'h0, 8'h00);
        chk("disabled", 8'h07, q[7:0]);
        chk("disabled pin", 8'h01, {6'h0, pinOut, pinOeN});
        acc(1, 2'h0, 8'hB7); tick(6); sys_rst <= 1'h1; tick(2); sys_rst <= 1'h0; tick(1);
        acc(0, 2'h0, 8'h00); chk("ctrl after reset", 8'h00, q[7:0]);
        chk("irq after reset", 8'h00, {6'h0, cmpIrq, irq});
        chk("wake after reset", 8'h00, {7'h0, wake});
        stop_test;
    end
endmodule
